/* core/tsi_pkg.sv */
// Summary of operation
// - Code 0000 leaves a slot unassigned; 0001 switches all eight PCM bits.
// - Code 0010 switches PCM bits 3..0, code 0011 switches bits 7..4.
// - Codes 0100..0111 switch PCM bit pairs 1..0, 3..2, 5..4, 7..6.
// - Serial-side bit positions of switched slots come from the subchannel control bits.
// - Downstream pre-processed slots use codes 1000, 1010, 1011 or a PCM code.
// - Upstream pre-processed slots use codes 1000, 0000, 1010, 1011 or a PCM code.
// - Writing code 1001 makes a slot processor access and stores the data byte.
// - Processor-access slots exchange the control-memory data byte with the serial slot.
// - Processor-access data fields are written and read with the ordinary data access.
// - A code read returns the 4-bit code in the data register low bits.
// - Address bit 7 picks upstream or downstream memory; bits 6..0 the slot.
// - The data register carries the byte to or from the addressed location.
// - Channel A transfer byte goes msb first on the serial line.
// - Channel B transfer byte goes msb first on the serial line.
// - Receive address A bit 7 picks PCM (0) or serial interface (1).
// - Channel A captures the slot named by its low seven receive address bits.
// - Receive address B bit 7 picks PCM (0) or serial interface (1).
// - Channel B captures the slot named by its low seven receive address bits.
// - A code write stores the code and the data register byte together.
package tsi_pkg;
    localparam logic [3:0] TSI_OFS_CONTROL = 4'h0;
    localparam logic [3:0] TSI_OFS_ADDRESS = 4'h1;
    localparam logic [3:0] TSI_OFS_DATA = 4'h2;
    localparam logic [3:0] TSI_OFS_XFER_A = 4'h3;
    localparam logic [3:0] TSI_OFS_XFER_B = 4'h4;
    localparam logic [3:0] TSI_OFS_RXADDR_A = 4'h5;
    localparam logic [3:0] TSI_OFS_RXADDR_B = 4'h6;
    localparam logic [7:0] TSI_RESET_BYTE = 8'h00;
    localparam logic [7:0] TSI_IDLE_BYTE = 8'hFF;
    localparam int TSI_DIR_BIT = 7;
    localparam int TSI_RWS_BIT = 7;
    localparam logic [3:0] TSI_CODE_UNASSIGNED = 4'h0;
    localparam logic [3:0] TSI_CODE_64K = 4'h1;
    localparam logic [3:0] TSI_CODE_32K_LO = 4'h2;
    localparam logic [3:0] TSI_CODE_32K_HI = 4'h3;
    localparam logic [3:0] TSI_CODE_16K_10 = 4'h4;
    localparam logic [3:0] TSI_CODE_16K_32 = 4'h5;
    localparam logic [3:0] TSI_CODE_16K_54 = 4'h6;
    localparam logic [3:0] TSI_CODE_16K_76 = 4'h7;
    localparam logic [3:0] TSI_CODE_PRE_D = 4'h8;
    localparam logic [3:0] TSI_CODE_CPU = 4'h9;
    localparam logic [3:0] TSI_CODE_PRE_SIG_E = 4'hA;
    localparam logic [3:0] TSI_CODE_PRE_SIG_O = 4'hB;
    localparam logic [3:0] TSI_MOC_CM_DATA = 4'h9;
    localparam logic [3:0] TSI_MOC_CM_CODE = 4'hE;
    localparam logic [3:0] TSI_MOC_TRI_ONE = 4'hC;
    localparam logic [3:0] TSI_MOC_TRI_ALL = 4'hD;
endpackage : tsi_pkg

/* core/tsi_sync_capture.sv */
module tsi_sync_capture
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Receive address register
    input wire logic [7:0] rx_addr,
    // Slot streams
    input wire logic pcm_valid,
    input wire logic [6:0] pcm_slot,
    input wire logic [7:0] pcm_byte,
    input wire logic cfi_valid,
    input wire logic [6:0] cfi_slot,
    input wire logic [7:0] cfi_byte,
    // Processor write
    input wire logic cpu_we,
    input wire logic [7:0] cpu_wdata,
    // Buffered byte, msb is the first serial bit
    output logic [7:0] data_q
);
    import tsi_pkg::*;

    typedef struct packed {
        logic [7:0] data;
    } tsi_cap_t;

    tsi_cap_t s_q;
    tsi_cap_t s_d;
    logic hit;

    always_comb
    begin
        s_d = s_q;
        // Interface select in bit 7, slot in bits 6..0
        hit = rx_addr[TSI_DIR_BIT] ? (cfi_valid && cfi_slot == rx_addr[6:0])
                                   : (pcm_valid && pcm_slot == rx_addr[6:0]);
        if (cpu_we)
        begin
            s_d.data = cpu_wdata;
        end
        // Capture wins over a processor write in the same cycle
        if (hit)
        begin
            s_d.data = rx_addr[TSI_DIR_BIT] ? cfi_byte : pcm_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign data_q = s_q.data;

    property p_capture_pcm;
        @(posedge ref_clk) disable iff (!rst_b)
        (!rx_addr[TSI_DIR_BIT] && pcm_valid && pcm_slot == rx_addr[6:0]) |=> data_q == $past(pcm_byte);
    endproperty
    a_capture_pcm: assert property (p_capture_pcm) else $error("pcm slot not captured");

    property p_capture_cfi;
        @(posedge ref_clk) disable iff (!rst_b)
        (rx_addr[TSI_DIR_BIT] && cfi_valid && cfi_slot == rx_addr[6:0]) |=> data_q == $past(cfi_byte);
    endproperty
    a_capture_cfi: assert property (p_capture_cfi) else $error("serial slot not captured");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (!hit && !cpu_we) |=> $stable(data_q);
    endproperty
    a_hold: assert property (p_hold) else $error("transfer byte changed without cause");
endmodule : tsi_sync_capture

/* core/tsi_access_core.sv */
module tsi_access_core
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Processor bus, demultiplexed, active low strobes
    input wire logic bus_cs_b,
    input wire logic bus_wr_b,
    input wire logic bus_rd_b,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_rdata_oe,
    // Status and modes
    output logic access_busy_flag,
    input wire logic [1:0] subchannel_control_reg,
    // PCM side slot streams
    input wire logic pcm_in_valid,
    input wire logic [6:0] pcm_in_slot,
    input wire logic [7:0] pcm_in_byte,
    input wire logic pcm_out_req,
    input wire logic [6:0] pcm_out_slot,
    output logic pcm_out_valid,
    output logic [7:0] pcm_out_byte,
    // Configurable serial side slot streams
    input wire logic cfi_in_valid,
    input wire logic [6:0] cfi_in_slot,
    input wire logic [7:0] cfi_in_byte,
    input wire logic cfi_out_req,
    input wire logic [6:0] cfi_out_slot,
    output logic cfi_out_valid,
    output logic [7:0] cfi_out_byte
);
    import tsi_pkg::*;

    typedef struct packed {
        logic wr_prev;
        logic busy;
        logic [7:0] control;
        logic [7:0] address;
        logic [7:0] data;
        logic [7:0] rxaddr_a;
        logic [7:0] rxaddr_b;
        logic [7:0] rdata;
        logic pcm_val;
        logic [7:0] pcm_out;
        logic cfi_val;
        logic [7:0] cfi_out;
    } tsi_core_t;

    tsi_core_t s_q;
    tsi_core_t s_d;

    // Index is {direction, slot}; upstream when bit 7 is set
    logic [3:0] cm_code [256];
    logic [7:0] cm_data [256];
    logic [7:0] dm_data [256];

    logic wr_take;
    logic rd_act;
    logic [7:0] xfer_a;
    logic [7:0] xfer_b;
    logic [7:0] mem_idx;
    logic [3:0] moc;
    logic [3:0] control_memory_code;
    logic rws;
    logic op_cm_data;
    logic op_cm_code_wr;
    logic op_cm_code_rd;
    logic op_dm;
    logic [7:0] dn_idx;
    logic [7:0] up_idx;
    logic [3:0] dn_code;
    logic [3:0] up_code;
    logic [7:0] up_dm_idx;
    logic [7:0] up_dm_new;

    function automatic logic [7:0] tsi_width_mask(input logic [3:0] code);
        unique case (code)
            TSI_CODE_64K: tsi_width_mask = 8'hFF;
            TSI_CODE_32K_LO, TSI_CODE_32K_HI: tsi_width_mask = 8'h0F;
            TSI_CODE_16K_10, TSI_CODE_16K_32, TSI_CODE_16K_54, TSI_CODE_16K_76: tsi_width_mask = 8'h03;
            default: tsi_width_mask = 8'h00;
        endcase
    endfunction : tsi_width_mask

    function automatic logic [2:0] tsi_pcm_shift(input logic [3:0] code);
        unique case (code)
            TSI_CODE_32K_HI, TSI_CODE_16K_54: tsi_pcm_shift = 3'h4;
            TSI_CODE_16K_32: tsi_pcm_shift = 3'h2;
            TSI_CODE_16K_76: tsi_pcm_shift = 3'h6;
            default: tsi_pcm_shift = 3'h0;
        endcase
    endfunction : tsi_pcm_shift

    function automatic logic [2:0] tsi_cfi_shift(input logic [3:0] code, input logic [1:0] sc);
        logic [7:0] wm;
        wm = tsi_width_mask(code);
        if (wm == 8'h0F)
        begin
            tsi_cfi_shift = sc[0] ? 3'h0 : 3'h4;
        end
        else if (wm == 8'h03)
        begin
            tsi_cfi_shift = {~sc, 1'b0};
        end
        else
        begin
            tsi_cfi_shift = 3'h0;
        end
    endfunction : tsi_cfi_shift

    assign wr_take = !bus_cs_b && !bus_wr_b && !s_q.wr_prev;
    assign rd_act = !bus_cs_b && !bus_rd_b;
    assign mem_idx = s_q.address;
    assign rws = s_q.control[TSI_RWS_BIT];
    assign moc = s_q.control[6:3];
    assign control_memory_code = s_q.control[3:0];
    assign op_cm_data = moc == TSI_MOC_CM_DATA && s_q.control[2:0] == 3'h0;
    assign op_cm_code_wr = !rws && s_q.control[6:4] == TSI_MOC_CM_CODE[3:1];
    assign op_cm_code_rd = rws && moc == TSI_MOC_CM_CODE && s_q.control[2:0] == 3'h0;
    assign op_dm = tsi_width_mask(moc) != 8'h00 && s_q.control[2:0] == 3'h0;

    // Serial-side lookups
    assign dn_idx = {1'b0, cfi_out_slot};
    assign dn_code = cm_code[dn_idx];
    assign up_idx = {1'b1, cfi_in_slot};
    assign up_code = cm_code[up_idx];
    assign up_dm_idx = {1'b1, cm_data[up_idx][6:0]};

    always_comb
    begin
        up_dm_new = dm_data[up_dm_idx]
            & ~(tsi_width_mask(up_code) << tsi_pcm_shift(up_code))
            | (((cfi_in_byte >> tsi_cfi_shift(up_code, subchannel_control_reg)) & tsi_width_mask(up_code))
                << tsi_pcm_shift(up_code));
    end

    always_comb
    begin
        s_d = s_q;
        s_d.wr_prev = !bus_cs_b && !bus_wr_b;
        if (wr_take)
        begin
            unique case (bus_addr)
                TSI_OFS_CONTROL:
                begin
                    s_d.control = bus_wdata;
                    s_d.busy = 1'b1;
                end
                TSI_OFS_ADDRESS: s_d.address = bus_wdata;
                TSI_OFS_DATA: s_d.data = bus_wdata;
                TSI_OFS_RXADDR_A: s_d.rxaddr_a = bus_wdata;
                TSI_OFS_RXADDR_B: s_d.rxaddr_b = bus_wdata;
                default:
                begin
                end
            endcase
        end
        // One cycle per memory operation; reads land in the data register
        if (s_q.busy)
        begin
            // A control write landing here restarts the op, so the set wins
            s_d.busy = wr_take && bus_addr == TSI_OFS_CONTROL;
            if (rws && op_cm_data)
            begin
                s_d.data = cm_data[mem_idx];
            end
            else if (op_cm_code_rd)
            begin
                s_d.data = {4'h0, cm_code[mem_idx]};
            end
            else if (rws && op_dm)
            begin
                s_d.data = dm_data[mem_idx];
            end
        end
        if (rd_act)
        begin
            unique case (bus_addr)
                TSI_OFS_CONTROL: s_d.rdata = s_q.control;
                TSI_OFS_ADDRESS: s_d.rdata = s_q.address;
                TSI_OFS_DATA: s_d.rdata = s_q.data;
                TSI_OFS_XFER_A: s_d.rdata = xfer_a;
                TSI_OFS_XFER_B: s_d.rdata = xfer_b;
                TSI_OFS_RXADDR_A: s_d.rdata = s_q.rxaddr_a;
                TSI_OFS_RXADDR_B: s_d.rdata = s_q.rxaddr_b;
                default: s_d.rdata = TSI_RESET_BYTE;
            endcase
        end
        // Serial slot answers, one cycle after the request
        s_d.pcm_val = pcm_out_req;
        s_d.pcm_out = dm_data[{1'b1, pcm_out_slot}];
        s_d.cfi_val = cfi_out_req;
        if (dn_code == TSI_CODE_CPU)
        begin
            s_d.cfi_out = cm_data[dn_idx];
        end
        else if (tsi_width_mask(dn_code) != 8'h00)
        begin
            s_d.cfi_out = TSI_IDLE_BYTE
                & ~(tsi_width_mask(dn_code) << tsi_cfi_shift(dn_code, subchannel_control_reg))
                | (((dm_data[{1'b0, cm_data[dn_idx][6:0]}] >> tsi_pcm_shift(dn_code)) & tsi_width_mask(dn_code))
                    << tsi_cfi_shift(dn_code, subchannel_control_reg));
        end
        else
        begin
            // Unassigned and pre-processed slots idle here; other units own them
            s_d.cfi_out = TSI_IDLE_BYTE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Memories carry no reset; processor operation written last so it wins a clash
    always_ff @(posedge ref_clk)
    begin
        if (pcm_in_valid)
        begin
            dm_data[{1'b0, pcm_in_slot}] <= pcm_in_byte;
        end
        if (cfi_in_valid && up_code == TSI_CODE_CPU)
        begin
            cm_data[up_idx] <= cfi_in_byte;
        end
        else if (cfi_in_valid && tsi_width_mask(up_code) != 8'h00)
        begin
            dm_data[up_dm_idx] <= up_dm_new;
        end
        if (s_q.busy && !rws)
        begin
            if (op_cm_code_wr)
            begin
                cm_code[mem_idx] <= control_memory_code;
                cm_data[mem_idx] <= s_q.data;
            end
            else if (op_cm_data)
            begin
                cm_data[mem_idx] <= s_q.data;
            end
            else if (op_dm)
            begin
                dm_data[mem_idx] <= dm_data[mem_idx] & ~(tsi_width_mask(moc) << tsi_pcm_shift(moc))
                    | (s_q.data & (tsi_width_mask(moc) << tsi_pcm_shift(moc)));
            end
        end
    end

    tsi_sync_capture u_cap_a
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rx_addr(s_q.rxaddr_a),
        .pcm_valid(pcm_in_valid),
        .pcm_slot(pcm_in_slot),
        .pcm_byte(pcm_in_byte),
        .cfi_valid(cfi_in_valid),
        .cfi_slot(cfi_in_slot),
        .cfi_byte(cfi_in_byte),
        .cpu_we(wr_take && bus_addr == TSI_OFS_XFER_A),
        .cpu_wdata(bus_wdata),
        .data_q(xfer_a)
    );

    tsi_sync_capture u_cap_b
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rx_addr(s_q.rxaddr_b),
        .pcm_valid(pcm_in_valid),
        .pcm_slot(pcm_in_slot),
        .pcm_byte(pcm_in_byte),
        .cfi_valid(cfi_in_valid),
        .cfi_slot(cfi_in_slot),
        .cfi_byte(cfi_in_byte),
        .cpu_we(wr_take && bus_addr == TSI_OFS_XFER_B),
        .cpu_wdata(bus_wdata),
        .data_q(xfer_b)
    );

    assign bus_rdata = s_q.rdata;
    assign bus_rdata_oe = rd_act;
    assign access_busy_flag = s_q.busy;
    assign pcm_out_valid = s_q.pcm_val;
    assign pcm_out_byte = s_q.pcm_out;
    assign cfi_out_valid = s_q.cfi_val;
    assign cfi_out_byte = s_q.cfi_out;

    property p_busy_window;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_take && bus_addr == TSI_OFS_CONTROL) |=> access_busy_flag ##1 !access_busy_flag;
    endproperty
    a_busy_window: assert property (p_busy_window) else $error("busy window not one cycle");

    property p_code_read;
        @(posedge ref_clk) disable iff (!rst_b)
        (s_q.busy && op_cm_code_rd) |=> s_q.data == {4'h0, cm_code[$past(mem_idx)]};
    endproperty
    a_code_read: assert property (p_code_read) else $error("code read not in low nibble");

    property p_code_write;
        @(posedge ref_clk) disable iff (!rst_b)
        (s_q.busy && op_cm_code_wr) |=> cm_code[$past(mem_idx)] == $past(control_memory_code)
            && cm_data[$past(mem_idx)] == $past(s_q.data);
    endproperty
    a_code_write: assert property (p_code_write) else $error("code and data not stored together");

    property p_cpu_slot_init;
        @(posedge ref_clk) disable iff (!rst_b)
        (s_q.busy && op_cm_code_wr && control_memory_code == TSI_CODE_CPU && !(cfi_in_valid && up_idx == mem_idx))
            |=> cm_code[$past(mem_idx)] == TSI_CODE_CPU;
    endproperty
    a_cpu_slot_init: assert property (p_cpu_slot_init) else $error("processor access code lost");

    property p_cpu_slot_out;
        @(posedge ref_clk) disable iff (!rst_b)
        (cfi_out_req && dn_code == TSI_CODE_CPU) |=> cfi_out_valid && cfi_out_byte == $past(cm_data[dn_idx]);
    endproperty
    a_cpu_slot_out: assert property (p_cpu_slot_out) else $error("processor slot byte not sent");

    property p_unassigned_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        (cfi_out_req && dn_code == TSI_CODE_UNASSIGNED) |=> cfi_out_byte == TSI_IDLE_BYTE;
    endproperty
    a_unassigned_idle: assert property (p_unassigned_idle) else $error("unassigned slot not idle");

    property p_full_switch;
        @(posedge ref_clk) disable iff (!rst_b)
        (cfi_out_req && dn_code == TSI_CODE_64K) |=> cfi_out_byte == $past(dm_data[{1'b0, cm_data[dn_idx][6:0]}]);
    endproperty
    a_full_switch: assert property (p_full_switch) else $error("64k slot byte mismatch");

    property p_dir_select;
        @(posedge ref_clk) disable iff (!rst_b)
        (s_q.busy && rws && op_cm_data) |=> s_q.data == cm_data[{$past(s_q.address[TSI_DIR_BIT]), $past(s_q.address[6:0])}];
    endproperty
    a_dir_select: assert property (p_dir_select) else $error("wrong memory block read");
endmodule : tsi_access_core

/* test/tsi_host_model.sv */
module tsi_host_model
    import tsi_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Bus strobes and data
    output logic bus_cs_b,
    output logic bus_wr_b,
    output logic bus_rd_b,
    output logic [3:0] bus_addr,
    output logic [7:0] bus_wdata,
    // Answers from the device
    input wire logic [7:0] bus_rdata,
    input wire logic access_busy_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    int fault = 0;
    initial
    begin
        bus_cs_b = 1'b1;
        bus_wr_b = 1'b1;
        bus_rd_b = 1'b1;
        bus_addr = 4'hF;
        bus_wdata = 8'h00;
    end
    // Idle bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_cs_b <= 1'b0;
        bus_wr_b <= 1'b0;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_cs_b <= 1'b1;
        bus_wr_b <= 1'b1;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_cs_b <= 1'b0;
        bus_rd_b <= 1'b0;
        bus_addr <= a;
        repeat (2) @(posedge ref_clk);
        d = bus_rdata;
        bus_cs_b <= 1'b1;
        bus_rd_b <= 1'b1;
        bus_addr <= ~a;
    endtask : rd
    // Busy must read clear before a new access starts
    task automatic ctl(input logic [7:0] c);
        int n;
        n = 0;
        while (access_busy_flag !== 1'b0 && n < 16)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 16)
            fault++;
        wr(TSI_OFS_CONTROL, c);
        repeat (3) @(posedge ref_clk);
    endtask : ctl
endmodule : tsi_host_model

/* test/tsi_memory_access_sync_transfer_tb.sv */
module tsi_memory_access_sync_transfer_tb
    import tsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Slots legal in every port mode
    localparam logic [6:0] PSLOT = 7'h08;
    localparam logic [6:0] PSLOT2 = 7'h31;
    localparam logic [6:0] CSLOT = 7'h11;
    localparam logic [6:0] CSLOT2 = 7'h48;
    typedef struct packed {logic [3:0] code; logic [1:0] sc; logic [7:0] pcm; logic [7:0] exp;} tsi_row_t;
    tsi_row_t rows [17] = '{
        '{4'h1, 2'h0, 8'h93, 8'h93}, '{4'h1, 2'h3, 8'h93, 8'h93}, '{4'h2, 2'h0, 8'h93, 8'h3F},
        '{4'h2, 2'h1, 8'h93, 8'hF3}, '{4'h3, 2'h2, 8'h93, 8'h9F}, '{4'h3, 2'h3, 8'h93, 8'hF9},
        '{4'h4, 2'h1, 8'h6C, 8'hCF}, '{4'h5, 2'h0, 8'h93, 8'h3F}, '{4'h5, 2'h3, 8'h93, 8'hFC},
        '{4'h6, 2'h1, 8'h93, 8'hDF}, '{4'h6, 2'h2, 8'h93, 8'hF7}, '{4'h7, 2'h0, 8'h93, 8'hBF},
        '{4'h7, 2'h3, 8'h93, 8'hFE}, '{4'h0, 2'h0, 8'h93, 8'hFF}, '{4'h8, 2'h0, 8'h93, 8'hFF},
        '{4'hA, 2'h1, 8'h93, 8'hFF}, '{4'hB, 2'h2, 8'h93, 8'hFF}};
    logic ref_clk = 1'b0;
    logic rst_b, bus_cs_b, bus_wr_b, bus_rd_b, bus_rdata_oe, access_busy_flag;
    logic pcm_in_valid, cfi_in_valid, pcm_out_req, cfi_out_req, pcm_out_valid, cfi_out_valid;
    logic [1:0] subchannel_control_reg;
    logic [3:0] bus_addr;
    logic [6:0] pcm_in_slot, cfi_in_slot, pcm_out_slot, cfi_out_slot;
    logic [7:0] bus_wdata, bus_rdata, pcm_in_byte, cfi_in_byte, pcm_out_byte, cfi_out_byte, got;
    int err_count = 0;
    int tests_run = 0;
    int busy_len = 0;
    int busy_max = 0;
    int oe_bad = 0;

    tsi_access_core uut (.ref_clk, .rst_b, .bus_cs_b, .bus_wr_b, .bus_rd_b, .bus_addr, .bus_wdata,
        .bus_rdata, .bus_rdata_oe, .access_busy_flag, .subchannel_control_reg,
        .pcm_in_valid, .pcm_in_slot, .pcm_in_byte, .pcm_out_req, .pcm_out_slot, .pcm_out_valid,
        .pcm_out_byte, .cfi_in_valid, .cfi_in_slot, .cfi_in_byte, .cfi_out_req, .cfi_out_slot,
        .cfi_out_valid, .cfi_out_byte);
    tsi_host_model host (.ref_clk, .bus_cs_b, .bus_wr_b, .bus_rd_b, .bus_addr, .bus_wdata,
        .bus_rdata, .access_busy_flag);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        busy_len <= (access_busy_flag === 1'b1) ? busy_len + 1 : 0;
        if (busy_len > busy_max)
            busy_max <= busy_len;
    end
    // Enable looked at mid-cycle, where strobes and output have settled
    always @(negedge ref_clk)
    begin
        if (rst_b === 1'b1 && bus_rdata_oe !== (!bus_cs_b && !bus_rd_b))
            oe_bad <= oe_bad + 1;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // One slot pulse; released lines go inverted
    task automatic feed(input bit configurable_serial_interface, input logic [6:0] s, input logic [7:0] b);
        @(posedge ref_clk);
        cfi_in_valid <= configurable_serial_interface;
        pcm_in_valid <= !configurable_serial_interface;
        {pcm_in_slot, cfi_in_slot, pcm_in_byte, cfi_in_byte} <= {s, s, b, b};
        @(posedge ref_clk);
        {pcm_in_valid, cfi_in_valid} <= 2'b00;
        {pcm_in_slot, cfi_in_slot, pcm_in_byte, cfi_in_byte} <= {~s, ~s, ~b, ~b};
    endtask : feed
    task automatic fetch(input bit configurable_serial_interface, input logic [6:0] s, output logic [7:0] b);
        int n;
        @(posedge ref_clk);
        cfi_out_req <= configurable_serial_interface;
        pcm_out_req <= !configurable_serial_interface;
        {cfi_out_slot, pcm_out_slot} <= {s, s};
        @(posedge ref_clk);
        {cfi_out_req, pcm_out_req} <= 2'b00;
        n = 0;
        #1;
        while ((configurable_serial_interface ? cfi_out_valid : pcm_out_valid) !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        b = (n < 4) ? (configurable_serial_interface ? cfi_out_byte : pcm_out_byte) : 8'hXX;
    endtask : fetch
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        host.wr(TSI_OFS_ADDRESS, a);
        host.wr(TSI_OFS_DATA, d);
        host.ctl(c);
        host.rd(TSI_OFS_DATA, got);
    endtask : op
    task automatic check_regs();
        for (int a = 1; a <= 6; a++)
        begin
            host.rd(4'(a), got);
            chk(got, TSI_RESET_BYTE);
        end
    endtask : check_regs

    initial
    begin
        #100000;
        err_count++;
        complete_run();
    end
    initial
    begin
        rst_b = 1'b0;
        subchannel_control_reg = 2'h0;
        {pcm_in_valid, cfi_in_valid, pcm_out_req, cfi_out_req} = 4'h0;
        {pcm_in_slot, cfi_in_slot, pcm_out_slot, cfi_out_slot} = 28'h0;
        {pcm_in_byte, cfi_in_byte} = 16'h0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        check_regs();
        for (int a = 1; a <= 6; a++)
        begin
            host.wr(4'(a), 8'h30 + 8'(a));
            host.rd(4'(a), got);
            chk(got, 8'h30 + 8'(a));
        end
        host.wr(4'h7, 8'h5A);
        host.rd(4'h7, got);
        chk(got, 8'h00);
        for (int i = 0; i < 17; i++)
        begin
            feed(1'b0, PSLOT, rows[i].pcm);
            subchannel_control_reg <= rows[i].sc;
            op({1'b0, CSLOT}, {1'b0, PSLOT}, {4'h7, rows[i].code});
            op({1'b0, CSLOT}, 8'h00, 8'hF0);
            chk(got, {4'h0, rows[i].code});
            op({1'b0, CSLOT}, 8'h00, 8'hC8);
            chk(got, {1'b0, PSLOT});
            fetch(1'b1, CSLOT, got);
            chk(got, rows[i].exp);
        end
        op({1'b0, CSLOT2}, 8'h3C, 8'h79);
        fetch(1'b1, CSLOT2, got);
        chk(got, 8'h3C);
        op({1'b0, CSLOT2}, 8'hC3, 8'h48);
        fetch(1'b1, CSLOT2, got);
        chk(got, 8'hC3);
        op({1'b1, CSLOT2}, 8'h00, 8'h79);
        feed(1'b1, CSLOT2, 8'h5E);
        op({1'b1, CSLOT2}, 8'h00, 8'hC8);
        chk(got, 8'h5E);
        op({1'b0, CSLOT2}, 8'h00, 8'hC8);
        chk(got, 8'hC3);
        feed(1'b0, PSLOT2, 8'h11);
        op({1'b1, PSLOT2}, 8'h77, 8'h08);
        fetch(1'b0, PSLOT2, got);
        chk(got, 8'h77);
        op({1'b0, PSLOT2}, 8'h00, 8'h88);
        chk(got, 8'h11);
        op({1'b1, PSLOT2}, 8'h00, 8'h88);
        chk(got, 8'h77);
        // Narrow DM write keeps other bits; upstream serial merge lands in bits 7..4
        op({1'b1, PSLOT2}, 8'hA5, 8'h10);
        op({1'b1, PSLOT2}, 8'h00, 8'h88);
        chk(got, 8'h75);
        subchannel_control_reg <= 2'h2;
        op({1'b1, CSLOT}, {1'b0, PSLOT2}, 8'h73);
        feed(1'b1, CSLOT, 8'hB6);
        op({1'b1, PSLOT2}, 8'h00, 8'h88);
        chk(got, 8'hB5);
        // Same slot number on both interfaces tells the selects apart
        host.wr(TSI_OFS_RXADDR_A, {1'b0, CSLOT2});
        host.wr(TSI_OFS_RXADDR_B, {1'b1, CSLOT2});
        feed(1'b0, CSLOT2, 8'hA1);
        feed(1'b1, CSLOT2, 8'hB2);
        feed(1'b0, PSLOT2, 8'h44);
        host.rd(TSI_OFS_XFER_A, got);
        chk(got, 8'hA1);
        host.rd(TSI_OFS_XFER_B, got);
        chk(got, 8'hB2);
        host.wr(TSI_OFS_RXADDR_A, {1'b1, CSLOT2});
        host.wr(TSI_OFS_RXADDR_B, {1'b0, PSLOT2});
        feed(1'b1, CSLOT2, 8'hC3);
        feed(1'b0, PSLOT2, 8'hD4);
        feed(1'b0, PSLOT, 8'h55);
        host.rd(TSI_OFS_XFER_A, got);
        chk(got, 8'hC3);
        host.rd(TSI_OFS_XFER_B, got);
        chk(got, 8'hD4);
        chk(8'(busy_max), 8'h01);
        chk(8'(oe_bad), 8'h00);
        chk(8'(host.fault), 8'h00);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        check_regs();
        complete_run();
    end
endmodule : tsi_memory_access_sync_transfer_tb
